//--- src/tw_pkg.sv
// constants and carriers for the two-wire slave register port
// assumes one 100 MHz clock domain; bus pins arrive asynchronously
package tw_pkg;
   localparam int CLK_MHZ = 100;
   localparam int BUS_TIMEOUT_MS = 35;
   localparam int BUS_TIMEOUT_CYCLES = BUS_TIMEOUT_MS * 1000 * CLK_MHZ;
   localparam int STUCK_PULSES = 9;
   localparam logic [7:0] DEFAULT_BASE = 8'hb0;
   localparam logic [6:0] HS_MASTER_CODE = 7'h04; // 0000 1xx
   localparam logic [7:0] PAGE_REG_ADDR = 8'h00;
   localparam int NUM_PAGES = 2;
   localparam int PAGE_BYTES = 256;
   localparam int NUM_EVENTS = 4;
   // apb map of this port
   localparam logic [11:0] A_CTRL = 12'h000;
   localparam logic [11:0] A_STATUS = 12'h004;
   localparam logic [11:0] A_EVENT = 12'h008;
   localparam logic [11:0] A_MASK = 12'h00c;
   localparam logic [11:0] A_BASE = 12'h010;
   localparam int C_IF_EN = 0;
   localparam int C_TIMEOUT_EN = 1;
   localparam int C_HS_CONT = 2;
   localparam int C_REVERT = 3;
   localparam int C_REPEAT_WR = 4;
   localparam int C_IRQ_HIGH = 5;
   localparam int C_DRV_KIND = 6;
   localparam int C_SEQ_BUSY = 7;
   localparam logic [7:0] CTRL_RESET = 8'h03;
   typedef struct packed {
      logic scl;
      logic sda;
   } bus_pins_s;
   typedef struct packed {
      logic start;
      logic stop;
      logic rise;
      logic fall;
      logic sda;
   } bus_evt_s;
endpackage

//--- src/tw_line_sync.sv
// two-flop synchroniser and condition detector for scl and sda
// assumes raw pins asynchronous to pclk
`timescale 1ns/1ps
module tw_line_sync
   import tw_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire bus_pins_s pins,
   output bus_evt_s evt
);
   bus_pins_s meta, sync, prev;
   // first stage feeds only the second stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta <= '1;
         sync <= '1;
         prev <= '1;
      end else begin
         meta <= pins;
         sync <= meta;
         prev <= sync;
      end
   end
   // start: sda falls while scl high; stop: sda rises while scl high
   always_comb begin
      evt.start = prev.scl && sync.scl && prev.sda && !sync.sda;
      evt.stop = prev.scl && sync.scl && !prev.sda && sync.sda;
      evt.rise = !prev.scl && sync.scl;
      evt.fall = prev.scl && !sync.scl;
      evt.sda = sync.sda;
   end
endmodule

//--- src/tw_slave_port.sv
// two-wire slave port with register pages, apb control and event irq
// assumes open-drain scl/sda with external pull-ups; apb on pclk
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ps
//
// Function
// - slave only; default 8-bit address b0, base set by configuration
// - interface resets when scl idle over 35 ms, if enabled
// - stuck sda: release and idle after nine clock pulses
// - master code 0000 1xxx selects high speed for one transfer
// - never stretches scl; read data ready with no delay
// - continuous high-speed setting needs no master code
// - two pages of 256; address zero is page selector, lsb ignored
// - page write switches page, or reverts to page 0 if selected
// - consecutive slave addresses select page from address bits
// - all bytes are eight bits, msb first
// - start and stop conditions detected while scl high
// - acknowledge own address by holding sda low next clock
// - byte write: address, register, data; every byte acked
// - read: write pointer, restart with read, nack then stop
// - acked read byte increments pointer and sends next
// - nonexistent register reads as zero
// - consecutive write stores each byte at next address
// - repeated write mode: address/data pairs stored in turn
// - stop mid-message abandons it to idle; start abandons it and restarts at the address byte
// - level irq with polarity, held until all unmasked events cleared
// - events during event read or sequencer transition are deferred
module tw_slave_port
   import tw_pkg::*;
#(
   parameter int TIMEOUT_CYCLES = BUS_TIMEOUT_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic [NUM_EVENTS-1:0] event_in,
   output logic interrupt_request_out,
   output logic irq_oe,
   output logic high_speed
);
   typedef enum logic [5:0] {
      S_IDLE = 6'b000001,
      S_ADDR = 6'b000010,
      S_REG = 6'b000100,
      S_WDATA = 6'b001000,
      S_RDATA = 6'b010000,
      S_MACK = 6'b100000
   } tw_state_e;

   bus_evt_s ev;
   tw_state_e state;
   logic [7:0] shreg;
   logic [3:0] bitcnt;
   logic ack_phase;
   logic [7:0] ctrl;
   logic [7:0] slave_address_base;
   logic [NUM_EVENTS-1:0] ev_reg, ev_pend, ev_mask;
   logic [7:0] regs [NUM_PAGES][PAGE_BYTES];
   logic page;
   logic [7:0] ptr;
   logic hs_once;
   logic pair_addr;
   logic [31:0] idle_cnt;
   logic [3:0] stuck_cnt;
   logic bus_reset;
   logic ev_reading;
   logic [7:0] rd_byte;
   bus_pins_s raw_pins;

   // register read with zero for unmapped space
   function automatic logic [7:0] reg_read(input logic pg, input logic [7:0] a);
      if (a == PAGE_REG_ADDR) reg_read = {6'h00, pg, 1'b0}; // page value sits in bit 1
      else reg_read = regs[pg][a];
   endfunction

   // raw pins packed for the synchroniser; scl is the upper bit
   assign raw_pins = {scl_in, sda_in};

   // byte served at the next read slot, looked up ahead of the scl fall
   always_comb rd_byte = reg_read(page, ptr);

   tw_line_sync u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pins(raw_pins),
      .evt(ev)
   );

   // scl idle timeout and stuck-sda pulse count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idle_cnt <= '0;
         stuck_cnt <= '0;
      end else begin
         if (ev.rise || ev.fall || state == S_IDLE) idle_cnt <= '0;
         else if (ctrl[C_TIMEOUT_EN]) idle_cnt <= idle_cnt + 32'h1;
         // ack slots restart the count: a zero byte plus its ack is not a stuck line
         if (ev.start || ev.stop || ev.sda || ack_phase || state == S_MACK) stuck_cnt <= '0;
         else if (ev.rise && stuck_cnt != 4'hf) stuck_cnt <= stuck_cnt + 4'h1;
      end
   end
   assign bus_reset = (idle_cnt >= 32'(TIMEOUT_CYCLES))
      || (stuck_cnt >= 4'(STUCK_PULSES));

   // serial protocol engine; only shifts on scl edges, never holds scl
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= S_IDLE;
         shreg <= '0;
         bitcnt <= '0;
         ack_phase <= 1'b0;
         sda_out <= 1'b0;
         sda_oe <= 1'b0;
         ptr <= '0;
         page <= 1'b0;
         hs_once <= 1'b0;
         pair_addr <= 1'b0;
      end else if (bus_reset || ev.stop || !ctrl[C_IF_EN]) begin
         state <= S_IDLE;
         sda_oe <= 1'b0;
         ack_phase <= 1'b0;
         if (ev.stop) hs_once <= 1'b0;
      end else if (ev.start) begin
         state <= S_ADDR; // restart also lands here
         bitcnt <= '0;
         ack_phase <= 1'b0;
         sda_oe <= 1'b0;
      end else if (ev.rise && !ack_phase && state != S_IDLE && state != S_MACK
                   && state != S_RDATA) begin
         shreg <= {shreg[6:0], ev.sda}; // msb first
         bitcnt <= bitcnt + 4'h1;
      end else if (ev.rise && state == S_MACK) begin
         if (ev.sda) state <= S_IDLE; // nack ends read
         else begin
            state <= S_RDATA;
            ptr <= ptr + 8'h1;
            ack_phase <= 1'b1; // next fall loads the following byte
         end
      end else if (ev.fall) begin
         if (ack_phase) begin
            ack_phase <= 1'b0;
            sda_oe <= 1'b0;
            bitcnt <= '0;
            if (state == S_RDATA) begin
               shreg <= rd_byte; // preloaded, no delay
               sda_oe <= !rd_byte[7];
               bitcnt <= 4'h1;
            end
         end else if (state == S_RDATA) begin
            if (bitcnt == 4'h8) begin
               state <= S_MACK;
               sda_oe <= 1'b0;
            end else begin
               sda_oe <= !shreg[7 - 3'(bitcnt)];
               bitcnt <= bitcnt + 4'h1;
            end
         end else if (bitcnt == 4'h8) begin
            unique case (state)
               S_ADDR: begin
                  if (shreg[7:3] == HS_MASTER_CODE[6:2]) begin
                     hs_once <= 1'b1; // no ack to master code
                     state <= S_IDLE;
                  end else if (shreg[7:4] == slave_address_base[7:4]
                               && shreg[3:2] == slave_address_base[3:2]) begin
                     page <= shreg[1];
                     ack_phase <= 1'b1;
                     sda_oe <= 1'b1;
                     state <= shreg[0] ? S_RDATA : S_REG;
                     pair_addr <= 1'b0;
                  end else state <= S_IDLE;
               end
               S_REG: begin
                  ptr <= shreg;
                  ack_phase <= 1'b1;
                  sda_oe <= 1'b1;
                  state <= S_WDATA;
               end
               S_WDATA: begin
                  ack_phase <= 1'b1;
                  sda_oe <= 1'b1;
                  if (ctrl[C_REPEAT_WR] && pair_addr) begin
                     ptr <= shreg;
                     pair_addr <= 1'b0;
                  end else begin
                     if (ptr == PAGE_REG_ADDR)
                        page <= ctrl[C_REVERT] ? 1'b0 : shreg[1];
                     pair_addr <= ctrl[C_REPEAT_WR];
                     if (!ctrl[C_REPEAT_WR]) ptr <= ptr + 8'h1;
                  end
               end
               default: state <= S_IDLE;
            endcase
         end
      end
   end

   // register array; cleared at reset so unwritten addresses read as zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) regs <= '{default: '{default: '0}};
      else if (ev.fall && !ack_phase && state == S_WDATA && bitcnt == 4'h8
          && !(ctrl[C_REPEAT_WR] && pair_addr) && ptr != PAGE_REG_ADDR)
         regs[page][ptr] <= shreg;
   end

   assign high_speed = hs_once || ctrl[C_HS_CONT];

   // apb: zero wait states, error on unmapped address
   assign pready = 1'b1;
   assign pslverr = psel && penable && !(paddr == A_CTRL || paddr == A_STATUS
      || paddr == A_EVENT || paddr == A_MASK || paddr == A_BASE);
   assign ev_reading = psel && !pwrite && paddr == A_EVENT;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= CTRL_RESET;
         ev_mask <= '0;
         slave_address_base <= DEFAULT_BASE;
      end else if (psel && penable && pwrite) begin
         if (paddr == A_CTRL) ctrl <= pwdata[7:0];
         if (paddr == A_MASK) ev_mask <= pwdata[NUM_EVENTS-1:0];
         if (paddr == A_BASE) slave_address_base <= pwdata[7:0];
      end
   end

   // events: new ones wait in pending while reading or sequencer busy
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev_reg <= '0;
         ev_pend <= '0;
      end else begin
         logic [NUM_EVENTS-1:0] clr;
         logic hold;
         clr = (psel && penable && pwrite && paddr == A_EVENT) ?
               pwdata[NUM_EVENTS-1:0] : '0;
         hold = ev_reading || ctrl[C_SEQ_BUSY];
         if (hold) begin
            ev_pend <= ev_pend | event_in;
            ev_reg <= ev_reg & ~clr;
         end else begin
            ev_pend <= '0;
            ev_reg <= (ev_reg & ~clr) | ev_pend | event_in; // set wins
         end
      end
   end

   // irq level with polarity; open-drain drives only when asserted
   logic irq_active;
   assign irq_active = |(ev_reg & ~ev_mask);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         interrupt_request_out <= 1'b1;
         irq_oe <= 1'b0;
      end else begin
         interrupt_request_out <= irq_active ~^ ctrl[C_IRQ_HIGH];
         irq_oe <= ctrl[C_DRV_KIND] ? irq_active : 1'b1;
      end
   end

   // apb read data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prdata <= '0;
      else if (psel && !penable && !pwrite) begin
         unique case (paddr)
            A_CTRL: prdata <= {24'h0, ctrl};
            A_STATUS: prdata <= {24'h0, ptr[6:0], page};
            A_EVENT: prdata <= {28'h0, ev_reg};
            A_MASK: prdata <= {28'h0, ev_mask};
            A_BASE: prdata <= {24'h0, slave_address_base};
            default: prdata <= '0;
         endcase
      end
   end

   property p_ack_addr;
      @(posedge pclk) disable iff (!presetn)
      (ev.fall && state == S_ADDR && bitcnt == 4'h8 && shreg[7:2] ==
       slave_address_base[7:2] && ctrl[C_IF_EN] && !ev.stop && !bus_reset)
      |=> sda_oe;
   endproperty
   a_ack_addr: assert property (p_ack_addr) else $error("no address ack");

   property p_stop_idle;
      @(posedge pclk) disable iff (!presetn) ev.stop |=> state == S_IDLE;
   endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("stop not idle");

   property p_irq;
      @(posedge pclk) disable iff (!presetn)
      irq_active |=> interrupt_request_out == $past(ctrl[C_IRQ_HIGH]);
   endproperty
   a_irq: assert property (p_irq) else $error("irq level wrong");

   property p_stuck;
      @(posedge pclk) disable iff (!presetn)
      stuck_cnt >= 4'(STUCK_PULSES) |=> state == S_IDLE && !sda_oe;
   endproperty
   a_stuck: assert property (p_stuck) else $error("stuck bus not released");

   property p_hs;
      @(posedge pclk) disable iff (!presetn) ctrl[C_HS_CONT] |-> high_speed;
   endproperty
   a_hs: assert property (p_hs) else $error("hs mode missing");

   // a master code only lasts until the stop of its transfer
   property p_hs_end;
      @(posedge pclk) disable iff (!presetn)
      ev.stop && !ctrl[C_HS_CONT] |=> !high_speed;
   endproperty
   a_hs_end: assert property (p_hs_end) else $error("hs outlived transfer");

   property p_rd_load;
      @(posedge pclk) disable iff (!presetn)
      (ev.fall && ack_phase && state == S_RDATA && ctrl[C_IF_EN] && !ev.stop && !bus_reset)
      |=> sda_oe == !$past(rd_byte[7]) && shreg == $past(rd_byte);
   endproperty
   a_rd_load: assert property (p_rd_load) else $error("read byte not loaded");

   property p_pend;
      @(posedge pclk) disable iff (!presetn)
      ctrl[C_SEQ_BUSY] && |event_in |=> |ev_pend;
   endproperty
   a_pend: assert property (p_pend) else $error("deferred event lost");

   property p_timeout;
      @(posedge pclk) disable iff (!presetn)
      idle_cnt >= 32'(TIMEOUT_CYCLES) |=> state == S_IDLE;
   endproperty
   a_timeout: assert property (p_timeout) else $error("timeout no reset");

   property p_mack;
      @(posedge pclk) disable iff (!presetn)
      state == S_MACK && ev.rise && !ev.sda && !ev.stop && !ev.start && !bus_reset
      && ctrl[C_IF_EN] |=> ptr == $past(ptr) + 8'h1;
   endproperty
   a_mack: assert property (p_mack) else $error("pointer not advanced");
endmodule

//--- tb/tw_master_model.sv
// two-wire bus master model: drives scl, pulls sda low
// assumes a pull-up on sda; the bench supplies the line level
`timescale 1ns/1ps
module tw_master_model (
   input wire logic pclk,
   input wire logic sda_line,
   output logic scl,
   output logic sda_low
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // quarter of a 160 ns link period at 100 MHz
   task automatic q(input int n);
      repeat (4 * n) @(posedge pclk);
   endtask
   // start or repeated start: sda falls while scl high
   task automatic start();
      sda_low <= 1'b0;
      q(1);
      scl <= 1'b1;
      q(2);
      sda_low <= 1'b1;
      q(2);
      scl <= 1'b0;
      q(1);
   endtask
   // stop: sda rises while scl high
   task automatic stop();
      sda_low <= 1'b1;
      q(1);
      scl <= 1'b1;
      q(2);
      sda_low <= 1'b0;
      q(2);
   endtask
   // byte msb first plus ninth bit; all ones releases sda to read
   task automatic xfer(input logic [7:0] b, input logic ab, output logic [7:0] r,
                       output logic ak);
      logic [8:0] v;
      v = {b, ab};
      for (int i = 8; i >= 0; i--) begin
         sda_low <= ~v[i];
         q(1);
         scl <= 1'b1;
         q(2);
         v[i] = sda_line;
         scl <= 1'b0;
         q(1);
      end
      r = v[8:1];
      ak = v[0];
   endtask
endmodule

//--- tb/pmic_two_wire_slave_port_tb_top.sv
// bench for the two-wire slave port: apb master, bus master model
// assumes a pull-up on sda; short scl timeout parameter
`timescale 1ns/1ps
module pmic_two_wire_slave_port_tb_top;
   import tw_pkg::*;
   localparam int TO_CYC = 2000;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rv, seed = 24;
   logic pready, pslverr, sda_out, sda_oe, irq, irq_oe, hs, scl, sda_low, sda_line;
   logic [NUM_EVENTS-1:0] event_in = '0, evt_m;
   logic [7:0] rb;
   logic [7:0] q_m[$];
   logic [2:0] ak;
   int err_total = 0, check_count = 0, page_m = 0;
   // open drain with pull-up: low if anyone pulls
   assign sda_line = ~(sda_low | (sda_oe & ~sda_out));
   always #5 pclk = ~pclk;
   tw_slave_port #(.TIMEOUT_CYCLES(TO_CYC)) dut_u (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl),
      .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .event_in(event_in),
      .interrupt_request_out(irq), .irq_oe(irq_oe), .high_speed(hs));
   tw_master_model mm (.pclk(pclk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   // one apb transfer, waits for pready under a bound
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         err_total++;
         test_done();
      end
      rv = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic wr3(input logic [7:0] sa, input logic [7:0] ra, input logic [7:0] d);
      mm.start();
      mm.xfer(sa, 1'b1, rb, ak[2]);
      mm.xfer(ra, 1'b1, rb, ak[1]);
      mm.xfer(d, 1'b1, rb, ak[0]);
      mm.stop();
      chk(ak, 0, "write acks");
   endtask
   task automatic pg();
      apb(0, A_STATUS, 0);
      chk(rv[0], page_m[0], "page");
   endtask
   task automatic pulse();
      event_in <= evt_m;
      @(posedge pclk);
      event_in <= '0;
      repeat (4) @(posedge pclk);
   endtask
   // hang guard
   initial begin
      repeat (100000) @(posedge pclk);
      err_total++;
      test_done();
   end
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, A_CTRL, 0);
      chk(rv, 32'(CTRL_RESET), "ctrl reset");
      apb(0, A_BASE, 0);
      chk(rv, 32'h0b0, "base reset");
      chk(irq, 1, "irq idle");
      chk(irq_oe, 1, "push-pull oe");
      apb(0, 12'h020, 0);
      chk(e, 1, "unmapped");
      $display("test apb done");
      // page selector, lsb ignored, revert off
      wr3(8'hb0, 8'h00, 8'h02);
      page_m = 1;
      pg();
      wr3(8'hb0, 8'h00, 8'h03);
      pg();
      wr3(8'hb0, 8'h00, 8'h01);
      page_m = 0;
      pg();
      mm.start();
      mm.xfer(8'ha0, 1'b1, rb, ak[0]);
      mm.stop();
      chk(ak[0], 1, "foreign nack");
      // page from the slave address
      mm.start();
      mm.xfer(8'hb2, 1'b1, rb, ak[0]);
      mm.stop();
      page_m = 1;
      pg();
      // page selector read over the bus shows the page in bit 1
      mm.start();
      mm.xfer(8'hb2, 1'b1, rb, ak[0]);
      mm.xfer(8'h00, 1'b1, rb, ak[0]);
      mm.start();
      mm.xfer(8'hb3, 1'b1, rb, ak[0]);
      mm.xfer(8'hff, 1'b1, rb, ak[0]);
      mm.stop();
      chk(rb, 8'(page_m * 2), "page selector");
      wr3(8'hb0, 8'h00, 8'h00);
      page_m = 0;
      $display("test paging done");
      // acked read run over absent registers
      mm.start();
      mm.xfer(8'hb0, 1'b1, rb, ak[2]);
      mm.xfer(8'hfe, 1'b1, rb, ak[1]);
      mm.start();
      mm.xfer(8'hb1, 1'b1, rb, ak[0]);
      chk(ak, 0, "read acks");
      mm.xfer(8'hff, 1'b0, rb, ak[0]);
      chk(rb, 0, "read 1");
      mm.xfer(8'hff, 1'b1, rb, ak[0]);
      chk(rb, 0, "read 2");
      mm.stop();
      // consecutive write of random bytes, then an acked read-back run
      mm.start();
      mm.xfer(8'hb0, 1'b1, rb, ak[0]);
      mm.xfer(8'h10, 1'b1, rb, ak[0]);
      for (int i = 0; i < 3; i++) begin
         rv = xs();
         q_m.push_back(rv[7:0]);
         mm.xfer(rv[7:0], 1'b1, rb, ak[0]);
         chk(ak[0], 0, "burst ack");
      end
      mm.stop();
      mm.start();
      mm.xfer(8'hb0, 1'b1, rb, ak[0]);
      mm.xfer(8'h10, 1'b1, rb, ak[0]);
      mm.start();
      mm.xfer(8'hb1, 1'b1, rb, ak[0]);
      for (int i = 0; i < 3; i++) begin
         mm.xfer(8'hff, i == 2, rb, ak[0]);
         chk(rb, q_m.pop_front(), "burst read");
      end
      mm.stop();
      // master code then restart
      mm.start();
      mm.xfer(8'h08, 1'b1, rb, ak[0]);
      mm.start();
      mm.xfer(8'hb0, 1'b1, rb, ak[0]);
      chk({ak[0], hs}, 2'b01, "hs");
      mm.stop();
      apb(1, A_CTRL, 32'h07);
      @(posedge pclk);
      chk(hs, 1, "hs cont");
      // repeated write pairs end on the page selector
      apb(1, A_CTRL, 32'h13);
      mm.start();
      mm.xfer(8'hb0, 1'b1, rb, ak[0]);
      for (int i = 0; i < 4; i++) mm.xfer(i < 2 ? 8'h05 - i * 5 : 8'h02 * (i - 2),
                                         1'b1, rb, ak[1]);
      mm.stop();
      page_m = 1;
      pg();
      apb(1, A_CTRL, 32'h0b);
      // address b2 picks page 1 first, so only revert can leave page 0
      wr3(8'hb2, 8'h00, 8'h02);
      page_m = 0;
      pg();
      apb(1, A_CTRL, 32'h03);
      // new start mid-message abandons it
      mm.start();
      mm.xfer(8'hb0, 1'b1, rb, ak[0]);
      mm.xfer(8'h00, 1'b1, rb, ak[0]);
      mm.start();
      mm.xfer(8'h02, 1'b1, rb, ak[0]);
      mm.stop();
      chk(ak[0], 1, "abandon nack");
      pg();
      // scl stalls past the timeout, interface resets
      mm.start();
      mm.xfer(8'hb0, 1'b1, rb, ak[0]);
      repeat (TO_CYC + 100) @(posedge pclk);
      mm.xfer(8'h00, 1'b1, rb, ak[0]);
      mm.stop();
      chk(ak[0], 1, "timeout idle");
      $display("test bus done");
      // events raise, clear, mask and defer
      rv = xs();
      evt_m = rv[3:0] | 4'h1;
      pulse();
      apb(0, A_EVENT, 0);
      chk(rv[3:0], evt_m, "events");
      chk(irq, 0, "irq on");
      apb(1, A_EVENT, 32'(evt_m));
      repeat (3) @(posedge pclk);
      chk(irq, 1, "irq off");
      apb(1, A_CTRL, 32'h63);
      repeat (2) @(posedge pclk);
      chk(irq_oe, 0, "open drain idle");
      chk(irq, 0, "active high idle");
      apb(1, A_CTRL, 32'h03);
      apb(1, A_MASK, 32'h0f);
      pulse();
      chk(irq, 1, "masked");
      apb(1, A_EVENT, 32'h0f);
      apb(1, A_MASK, 0);
      apb(1, A_CTRL, 32'h83);
      pulse();
      apb(0, A_EVENT, 0);
      chk(rv[3:0], 0, "held back");
      apb(1, A_CTRL, 32'h03);
      repeat (3) @(posedge pclk);
      apb(0, A_EVENT, 0);
      chk(rv[3:0], evt_m, "posted");
      $display("test events done");
      test_done();
   end
endmodule
